//--- read_response_integrity_regs.vh
// Purpose: constants for the read response integrity block
// Assumes: byte addresses on a 32-bit AXI4-Lite register bus
// Notes: definitions only, no logic
`ifndef READ_RESPONSE_INTEGRITY_REGS_VH
`define READ_RESPONSE_INTEGRITY_REGS_VH

// Register byte offsets
`define OFS_CTRL 8'h00
`define OFS_ADDR 8'h04
`define OFS_TAG_STAGING_LOW 8'h08
`define OFS_OP 8'h0c
`define OFS_DLO 8'h10
`define OFS_DHI 8'h14
`define OFS_STAT 8'h18
`define OFS_FAULT 8'h1c
`define OFS_RLO 8'h20
`define OFS_RHI 8'h24

// Reset values
`define CTRL_RST 1'b0
`define ADDR_RST 32'h0000_0000
`define TAG_STAGING_LOW_RST 26'h000_0000
`define FAULT_RST 32'h0000_0000

// Operation codes
`define OP_TAG_STORE 3'h1
`define OP_STORE 3'h2
`define OP_LOAD 3'h3
`define OP_DFILL 3'h4
`define OP_IFILL 3'h5

// Command bus bits
`define CMD_GOOD_N 5
`define CMD_CHECK 4

// Cache fault record bits
`define FLT_BUS 26
`define FLT_DATA 25
`define FLT_TAG 24

// Tag entry layout
`define TAG_WP 28
`define TAG_W 27
`define TAG_P 26
`define CS_INVALID 2'h0
`define CS_SHARED 2'h1
`define CS_CLEAN 2'h2
`define CS_DIRTY 2'h3

// Address fields
`define VA_WAY 13
`define VA_SET_LSB 5
`define DW_LAST 2'h3

// AXI responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

//--- even_parity_bytes.v
// Purpose: even parity bit for each byte of a doubleword
// Assumes: 64-bit data, one parity bit per byte
// Notes: purely combinational
`timescale 1ns/100ps
`default_nettype none

module even_parity_bytes (
    input wire [63:0] data, // Doubleword to cover
    output wire [7:0] parity // Even parity, bit n for byte n
);

    ////////////////////////////////////////////////////////////////
    // Even parity per byte
    genvar i;
    generate
        for (i = 0; i < 8; i = i + 1) begin : g_byte
            assign parity[i] = ^data[8*i +: 8];
        end
    endgenerate

endmodule // even_parity_bytes

`default_nettype wire

//--- read_response_integrity.v
// Purpose: block read response intake with parity-protected cache storage
// Assumes: four doublewords per line, one per low strobe cycle
// Notes: registers on AXI4-Lite; pin inputs other than command parity pass two flip-flops
//
// Summary of operation
// RQ1: First returned doubleword is the requested one
// RQ2: Restart pipeline on first doubleword, not line end
// RQ3: Good-data bit high on first element: bus error
// RQ4: No first error: keep running while line fills
// RQ5: Ignore good-data bit after first element
// RQ6: Store response data with received check bits
// RQ7: Unflagged first-element parity error: cache error, bus source
// RQ8: Later bad parity stored; later access faults
// RQ9: Data-checking bit high: generate parity internally
// RQ10: External checker without parity drives data-checking high
// RQ11: Parityless memory: checking high, good-data low
// RQ12: Agent reports later-element errors by other means
// RQ13: Agent may retry reads, strobing only good data
// RQ14: Never check command bus parity
// RQ15: Tag holds two-bit state with even parities
// RQ16: Cache parity error raises cache error, not miss
// RQ17: Fault disable bit suppresses cache error exceptions
// RQ18: Tag store copies staging, keeps write-back bits
// RQ19: Instruction fill writes line with valid parity
// RQ20: Data store writes parity, sets write-back flags
// RQ21: Address bit 13 selects way for index operations
//
// Implementation choices: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`default_nettype none
`include "read_response_integrity_regs.vh"

module read_response_integrity #(
    parameter SET_W = 8 // Sets per way as a power of two, at most 8
) (
    input wire aclk, // System clock
    input wire aresetn, // Reset, active low
    input wire [7:0] awaddr, // Write address
    input wire [2:0] awprot, // Unused
    input wire awvalid, // Write address valid
    output reg awready, // Write address ready
    input wire [31:0] wdata, // Write data
    input wire [3:0] wstrb, // Write strobes
    input wire wvalid, // Write data valid
    output reg wready, // Write data ready
    output reg [1:0] bresp, // Write response
    output reg bvalid, // Write response valid
    input wire bready, // Write response ready
    input wire [7:0] araddr, // Read address
    input wire [2:0] arprot, // Unused
    input wire arvalid, // Read address valid
    output reg arready, // Read address ready
    output reg [31:0] rdata, // Read data
    output reg [1:0] rresp, // Read response
    output reg rvalid, // Read data valid
    input wire rready, // Read data ready
    input wire response_valid_strobe_n, // Element strobe pin
    input wire [8:0] system_command_bus, // Command bits per element
    input wire command_parity_signal, // Never read
    input wire [63:0] multiplexed_address_data_bus, // Response data
    input wire [7:0] address_data_check_bits, // Response parity
    output reg block_read_request, // One-cycle read request
    output reg [31:0] block_read_address, // Requested doubleword
    output reg pipeline_restart, // One-cycle early restart pulse
    output reg bus_error_exception, // One-cycle bus error pulse
    output reg cache_error_exception // One-cycle cache error pulse
);
    localparam LINE_W = SET_W + 1;
    localparam WORD_W = SET_W + 3;
    localparam S_IDLE = 4'b0001;
    localparam S_REQ = 4'b0010;
    localparam S_WAIT = 4'b0100;
    localparam S_FILL = 4'b1000;
    reg [28:0] tag_mem [0:(1<<LINE_W)-1];
    reg [71:0] data_mem [0:(1<<WORD_W)-1];
    reg v1_reg, v2_reg;
    reg [1:0] c1_reg, c2_reg;
    reg [63:0] d1_reg, d2_reg;
    reg [7:0] k1_reg, k2_reg;
    reg [3:0] state_reg;
    reg [1:0] cnt_reg;
    reg [1:0] first_dw_reg;
    reg [LINE_W-1:0] fill_line_reg;
    reg ifill_reg, berr_reg, disable_reg;
    reg [31:0] addr_reg, dlo_reg, dhi_reg, rlo_reg, rhi_reg, fault_reg;
    reg [25:0] tag_staging_low_reg;
    reg [31:0] rd_mux;
    reg [31:0] fault_next;
    reg mem_we, tag_we;
    reg [WORD_W-1:0] mem_idx;
    reg [71:0] mem_wdata;
    reg [LINE_W-1:0] tag_idx;
    reg [28:0] tag_wdata;
    wire [7:0] pin_par, st_par, rd_par;
    wire [31:0] wmask;
    wire wr_fire, ar_fire, op_go, elem, first, gen_par, pin_bad, tag_bad, data_bad;
    wire [LINE_W-1:0] line_idx;
    wire [WORD_W-1:0] word_idx, fill_idx;
    wire [28:0] tag_e;
    wire [71:0] rd_word;
    wire [2:0] op;
    ////////////////////////////////////////////////////////////////
    // Pin inputs cross two flip-flops; command parity is never sampled
    always @(posedge aclk) begin // RQ14
        if (!aresetn) begin
            v1_reg <= 1'b1;
            v2_reg <= 1'b1;
        end else begin
            v1_reg <= response_valid_strobe_n;
            v2_reg <= v1_reg;
        end
        c1_reg <= system_command_bus[`CMD_GOOD_N:`CMD_CHECK];
        c2_reg <= c1_reg;
        d1_reg <= multiplexed_address_data_bus;
        d2_reg <= d1_reg;
        k1_reg <= address_data_check_bits;
        k2_reg <= k1_reg;
    end
    ////////////////////////////////////////////////////////////////
    // Parity of incoming, stored and read-back doublewords
    even_parity_bytes u_pin_par (.data(d2_reg), .parity(pin_par));
    even_parity_bytes u_st_par (.data({dhi_reg, dlo_reg}), .parity(st_par));
    even_parity_bytes u_rd_par (.data(rd_word[63:0]), .parity(rd_par));
    ////////////////////////////////////////////////////////////////
    // Address decomposition: bit 13 picks the way
    assign line_idx = {addr_reg[`VA_WAY], addr_reg[`VA_SET_LSB +: SET_W]}; // RQ21
    assign word_idx = {line_idx, addr_reg[4:3]};
    // Sub-block order: element n is first doubleword xor n
    assign fill_idx = {fill_line_reg, first_dw_reg ^ cnt_reg}; // RQ1
    assign tag_e = tag_mem[line_idx];
    assign rd_word = data_mem[word_idx];
    assign tag_bad = (tag_e[`TAG_P] != ^tag_e[25:0]) | (tag_e[`TAG_WP] != tag_e[`TAG_W]); // RQ15
    assign data_bad = rd_par != rd_word[71:64];
    ////////////////////////////////////////////////////////////////
    // Bus handshakes and element qualification
    assign wmask = {{8{wstrb[3]}}, {8{wstrb[2]}}, {8{wstrb[1]}}, {8{wstrb[0]}}};
    assign wr_fire = awready & awvalid & wready & wvalid;
    assign ar_fire = arready & arvalid;
    assign op = wdata[2:0];
    // Refused unless idle, so one writer owns the arrays
    assign op_go = wr_fire & (awaddr[7:2] == `OFS_OP >> 2) & wstrb[0] & state_reg[0];
    assign elem = ~v2_reg & (state_reg[2] | state_reg[3]);
    assign first = state_reg[2];
    assign gen_par = c2_reg[0] | ifill_reg; // RQ9 RQ19
    assign pin_bad = pin_par != k2_reg;
    ////////////////////////////////////////////////////////////////
    // Array write port: fills, tag store and data store
    always @* begin
        mem_we = 1'b0;
        tag_we = 1'b0;
        mem_idx = word_idx;
        tag_idx = line_idx;
        mem_wdata = {st_par, dhi_reg, dlo_reg};
        tag_wdata = tag_e;
        if (elem && !berr_reg && !(first && c2_reg[1])) begin
            mem_we = 1'b1;
            mem_idx = fill_idx;
            // Received parity kept as is, bad or not, unless generating
            mem_wdata = {gen_par ? pin_par : k2_reg, d2_reg}; // RQ6 RQ8 RQ9
        end else if (op_go && op == `OP_STORE) begin
            mem_we = 1'b1; // RQ20
        end
        if (elem && cnt_reg == `DW_LAST) begin
            tag_we = 1'b1;
            tag_idx = fill_line_reg;
            tag_wdata[25:0] = berr_reg ? {`CS_INVALID, tag_staging_low_reg[23:0]} : tag_staging_low_reg;
            tag_wdata[`TAG_P] = ^tag_wdata[25:0];
            tag_wdata[`TAG_W] = 1'b0;
            tag_wdata[`TAG_WP] = 1'b0;
        end else if (op_go && op == `OP_TAG_STORE) begin
            tag_we = 1'b1;
            tag_wdata[25:0] = tag_staging_low_reg; // RQ18
            tag_wdata[`TAG_P] = ^tag_staging_low_reg; // RQ18
        end else if (op_go && op == `OP_STORE) begin
            tag_we = 1'b1;
            tag_wdata[`TAG_W] = 1'b1; // RQ20
            tag_wdata[`TAG_WP] = 1'b1; // RQ20
        end
    end
    // Arrays carry no reset: contents and parity start unknown
    always @(posedge aclk) begin
        if (mem_we) begin
            data_mem[mem_idx] <= mem_wdata;
        end
        if (tag_we) begin
            tag_mem[tag_idx] <= tag_wdata;
        end
    end
    ////////////////////////////////////////////////////////////////
    // Fault record: hardware set wins over a software clear
    always @* begin
        fault_next = fault_reg;
        if (wr_fire && awaddr[7:2] == `OFS_FAULT >> 2) begin
            fault_next = fault_reg & ~(wdata & wmask);
        end
        if (elem && first && !c2_reg[1] && !gen_par && pin_bad && !disable_reg) begin
            fault_next[`FLT_BUS] = 1'b1; // RQ7
        end
        if (op_go && op == `OP_LOAD && !disable_reg) begin
            fault_next[`FLT_TAG] = fault_next[`FLT_TAG] | tag_bad; // RQ16
            fault_next[`FLT_DATA] = fault_next[`FLT_DATA] | data_bad; // RQ16
        end
    end
    ////////////////////////////////////////////////////////////////
    // Response sequencer and exception pulses
    always @(posedge aclk) begin
        block_read_request <= 1'b0;
        pipeline_restart <= 1'b0;
        bus_error_exception <= 1'b0;
        cache_error_exception <= 1'b0;
        if (!aresetn) begin
            state_reg <= S_IDLE;
            cnt_reg <= 2'h0;
            first_dw_reg <= 2'h0;
            fill_line_reg <= {LINE_W{1'b0}};
            ifill_reg <= 1'b0;
            berr_reg <= 1'b0;
            block_read_address <= `ADDR_RST;
            fault_reg <= `FAULT_RST;
            rlo_reg <= 32'h0000_0000;
            rhi_reg <= 32'h0000_0000;
        end else begin
            fault_reg <= fault_next;
            case (state_reg)
                S_IDLE: begin
                    if (op_go && (op == `OP_DFILL || op == `OP_IFILL)) begin
                        state_reg <= S_REQ;
                        ifill_reg <= op == `OP_IFILL;
                        berr_reg <= 1'b0;
                        first_dw_reg <= addr_reg[4:3];
                        fill_line_reg <= line_idx;
                    end else if (op_go && op == `OP_LOAD) begin
                        rlo_reg <= rd_word[31:0];
                        rhi_reg <= rd_word[63:32];
                        // A bad entry faults rather than counting as a miss
                        cache_error_exception <= (tag_bad | data_bad) & ~disable_reg; // RQ16 RQ17
                    end
                end
                S_REQ: begin
                    block_read_request <= 1'b1;
                    block_read_address <= addr_reg;
                    cnt_reg <= 2'h0;
                    state_reg <= S_WAIT;
                end
                S_WAIT: begin
                    if (elem) begin
                        cnt_reg <= 2'h1;
                        state_reg <= S_FILL; // RQ4
                        if (c2_reg[1]) begin
                            bus_error_exception <= 1'b1; // RQ3
                            berr_reg <= 1'b1;
                        end else begin
                            pipeline_restart <= 1'b1; // RQ2
                            cache_error_exception <= !gen_par && pin_bad && !disable_reg; // RQ7 RQ17
                        end
                    end
                end
                S_FILL: begin
                    if (elem) begin // RQ5
                        cnt_reg <= cnt_reg + 2'h1;
                        if (cnt_reg == `DW_LAST) begin
                            state_reg <= S_IDLE;
                        end
                    end
                end
                default: state_reg <= S_IDLE;
            endcase
        end
    end
    ////////////////////////////////////////////////////////////////
    // Software registers, byte-lane writes
    always @(posedge aclk) begin
        if (!aresetn) begin
            disable_reg <= `CTRL_RST;
            addr_reg <= `ADDR_RST;
            tag_staging_low_reg <= `TAG_STAGING_LOW_RST;
            dlo_reg <= 32'h0000_0000;
            dhi_reg <= 32'h0000_0000;
        end else if (wr_fire) begin
            case ({awaddr[7:2], 2'b00})
                `OFS_CTRL: if (wstrb[0]) disable_reg <= wdata[0]; // RQ17
                `OFS_ADDR: addr_reg <= (addr_reg & ~wmask) | (wdata & wmask);
                `OFS_TAG_STAGING_LOW: tag_staging_low_reg <= (tag_staging_low_reg & ~wmask[25:0]) | (wdata[25:0] & wmask[25:0]);
                `OFS_DLO: dlo_reg <= (dlo_reg & ~wmask) | (wdata & wmask);
                `OFS_DHI: dhi_reg <= (dhi_reg & ~wmask) | (wdata & wmask);
                default: ;
            endcase
        end
    end
    ////////////////////////////////////////////////////////////////
    // Read data selection; unmapped addresses answer with an error
    always @* begin
        case ({araddr[7:2], 2'b00})
            `OFS_CTRL: rd_mux = {31'h0000_0000, disable_reg};
            `OFS_ADDR: rd_mux = addr_reg;
            `OFS_TAG_STAGING_LOW: rd_mux = {6'h00, tag_staging_low_reg};
            `OFS_DLO: rd_mux = dlo_reg;
            `OFS_DHI: rd_mux = dhi_reg;
            `OFS_STAT: rd_mux = {29'h0000_0000, berr_reg, state_reg[3], state_reg[1] | state_reg[2]};
            `OFS_FAULT: rd_mux = fault_reg;
            `OFS_RLO: rd_mux = rlo_reg;
            `OFS_RHI: rd_mux = rhi_reg;
            default: rd_mux = 32'h0000_0000;
        endcase
    end
    ////////////////////////////////////////////////////////////////
    // AXI4-Lite handshakes: take address and data together, one at a time
    always @(posedge aclk) begin
        if (!aresetn) begin
            awready <= 1'b0;
            wready <= 1'b0;
            bvalid <= 1'b0;
            bresp <= `RESP_OKAY;
            arready <= 1'b0;
            rvalid <= 1'b0;
            rresp <= `RESP_OKAY;
            rdata <= 32'h0000_0000;
        end else begin
            awready <= awvalid & wvalid & ~awready & ~bvalid;
            wready <= awvalid & wvalid & ~awready & ~bvalid;
            if (wr_fire) begin
                bvalid <= 1'b1;
                bresp <= (awaddr > `OFS_RHI + 8'h03) ? `RESP_SLVERR : `RESP_OKAY;
            end else if (bready) begin
                bvalid <= 1'b0;
            end
            arready <= arvalid & ~arready & ~rvalid;
            if (ar_fire) begin
                rvalid <= 1'b1;
                rdata <= rd_mux;
                rresp <= (araddr > `OFS_RHI + 8'h03) ? `RESP_SLVERR : `RESP_OKAY;
            end else if (rready) begin
                rvalid <= 1'b0;
            end
        end
    end
endmodule // read_response_integrity
`default_nettype wire

//--- read_response_integrity_props.sv
// Purpose: pin-side checks of the block read response intake
// Assumes: pulses follow the pin by three edges
// Notes: one tracking flop
`timescale 1ns/100ps
`default_nettype none
module read_response_integrity_props (
    input wire aclk, // System clock
    input wire aresetn, // Reset, active low
    input wire response_valid_strobe_n, // Element strobe pin
    input wire [8:0] system_command_bus, // Command bits per element
    input wire block_read_request, // Read request pulse
    input wire pipeline_restart, // Restart pulse
    input wire bus_error_exception, // Bus error pulse
    input wire cache_error_exception // Cache error pulse
);
    logic wait_reg;
    wire first_good = wait_reg && !response_valid_strobe_n && !system_command_bus[5];
    wire first_bad = wait_reg && !response_valid_strobe_n && system_command_bus[5];
    ////////////////////////////////////////
    // Set by a request, cleared by the first strobe
    always_ff @(posedge aclk)
        if (!aresetn) wait_reg <= 1'b0;
        else if (block_read_request) wait_reg <= 1'b1;
        else if (!response_valid_strobe_n) wait_reg <= 1'b0;
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    restart_good_a: assert property (first_good && system_command_bus[4] |-> ##3 pipeline_restart)
        else $error("restart missing");
    bus_err_a: assert property (first_bad |-> ##3 bus_error_exception && !pipeline_restart)
        else $error("bus error missing");
    late_bus_a: assert property (bus_error_exception |-> $past(first_bad, 3))
        else $error("stray bus error");
    restart_cause_a: assert property (pipeline_restart |-> $past(first_good, 3))
        else $error("stray restart");
    gen_parity_a: assert property (first_good && system_command_bus[4] |-> ##3 !cache_error_exception)
        else $error("cache error on own parity");
    restart_once_a: assert property (pipeline_restart |=> !pipeline_restart [*6])
        else $error("restart repeated");
    err_once_a: assert property (bus_error_exception |=> !bus_error_exception [*6])
        else $error("bus error repeated");
    req_idle_a: assert property (block_read_request |-> !wait_reg)
        else $error("early request");
endmodule // read_response_integrity_props
bind read_response_integrity read_response_integrity_props i_read_response_integrity_props (.aclk, .aresetn,
    .response_valid_strobe_n, .system_command_bus, .block_read_request, .pipeline_restart, .bus_error_exception,
    .cache_error_exception);
`default_nettype wire

//--- resp_agent_model.sv
// Purpose: system agent answering block reads
// Assumes: sub-block order, four doublewords per line, check bit n covers byte n
// Notes: data lines show inverted data when no element is offered
`timescale 1ns/100ps
`default_nettype none
module resp_agent_model (
    input wire aclk, // System clock
    input wire aresetn, // Reset, active low
    input wire block_read_request, // Read request pulse
    input wire [31:0] block_read_address, // Requested doubleword
    input wire [3:0] err_mask, // Good-data error per element
    input wire [3:0] bad_mask, // Corrupt parity per element
    input wire check_bit, // Data-checking bit
    input wire slow, // Stretch the answer
    output logic response_valid_strobe_n, // Element strobe
    output logic [8:0] system_command_bus, // Command bits
    output logic command_parity_signal, // Garbage parity
    output logic [63:0] multiplexed_address_data_bus, // Element data
    output logic [7:0] address_data_check_bits // Element parity
);
    integer n, i;
    logic [63:0] d;
    // Unique contents per line and position
    function [63:0] elem(input [31:0] a, input [1:0] dw);
        elem = {a[31:5], dw, 3'h5, ~a};
    endfunction
    ////////////////////////////////////////
    // Four elements, requested doubleword first
    initial begin
        response_valid_strobe_n = 1'b1;
        system_command_bus = 9'h000;
        command_parity_signal = 1'b0;
        multiplexed_address_data_bus = 64'h0;
        address_data_check_bits = 8'h00;
        forever begin
            @(posedge aclk);
            if (aresetn && block_read_request) begin
                repeat (slow ? 5 : 2) @(posedge aclk);
                for (n = 0; n < 4; n = n + 1) begin
                    d = elem(block_read_address, block_read_address[4:3] ^ n[1:0]);
                    for (i = 0; i < 8; i = i + 1)
                        address_data_check_bits[i] <= ^d[8*i+:8] ^ (bad_mask[n] && i == 0);
                    multiplexed_address_data_bus <= d;
                    system_command_bus <= {3'h0, err_mask[n], check_bit, 4'h0};
                    command_parity_signal <= ~command_parity_signal;
                    response_valid_strobe_n <= 1'b0;
                    @(posedge aclk);
                    // Slow answers leave scrambled gaps
                    if (slow) begin
                        response_valid_strobe_n <= 1'b1;
                        multiplexed_address_data_bus <= ~d;
                        @(posedge aclk);
                    end
                end
                response_valid_strobe_n <= 1'b1;
                multiplexed_address_data_bus <= ~d;
                system_command_bus <= ~system_command_bus;
            end
        end
    end
endmodule // resp_agent_model
`default_nettype wire

//--- read_response_integrity_bench.sv
// Purpose: self-checking bench for the read response integrity block
// Assumes: fault record bits 24 to 26, status bit 2 for bus error
// Notes: SET_W of 2 keeps cache initialisation short
`timescale 1ns/100ps
`default_nettype none
module read_response_integrity_bench;
    logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b1, arvalid = 1'b0;
    logic rready = 1'b1, chk = 1'b0, slow = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, v;
    logic [3:0] wstrb = 4'hf, em = 4'h0, bm = 4'h0;
    logic [1:0] r;
    wire awready, wready, bvalid, arready, rvalid, response_valid_strobe_n, command_parity_signal;
    wire block_read_request, pipeline_restart, bus_error_exception, cache_error_exception;
    wire [1:0] bresp, rresp;
    wire [31:0] rdata, block_read_address;
    wire [8:0] system_command_bus;
    wire [63:0] multiplexed_address_data_bus;
    wire [7:0] address_data_check_bits;
    integer n_errors = 0, samples_checked = 0, n_rs = 0, n_be = 0, n_ce = 0, e_rs = 0, e_be = 0, e_ce = 0;
    integer w, s, k;
    read_response_integrity #(.SET_W(2)) i_read_response_integrity (.aclk, .aresetn, .awaddr, .awprot(3'h0),
        .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arprot(3'h0),
        .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .response_valid_strobe_n, .system_command_bus,
        .command_parity_signal, .multiplexed_address_data_bus, .address_data_check_bits, .block_read_request,
        .block_read_address, .pipeline_restart, .bus_error_exception, .cache_error_exception);
    resp_agent_model i_resp_agent_model (.aclk, .aresetn, .block_read_request, .block_read_address,
        .err_mask(em), .bad_mask(bm), .check_bit(chk), .slow, .response_valid_strobe_n, .system_command_bus,
        .command_parity_signal, .multiplexed_address_data_bus, .address_data_check_bits);
    ////////////////////////////////////////
    // Clock; pulse tallies start after reset
    initial forever #5 aclk = ~aclk;
    always @(posedge aclk) begin
        if (aresetn) begin
            n_rs <= n_rs + pipeline_restart;
            n_be <= n_be + bus_error_exception;
            n_ce <= n_ce + cache_error_exception;
        end
    end
    task check(input [8*9:1] nm, input [63:0] seen, input [63:0] exp);
        samples_checked = samples_checked + 1;
        if (seen !== exp) begin
            n_errors = n_errors + 1;
            $display("ERROR %0s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // Answers are sampled at the falling edge; bready and rready stay high
    task wr(input [7:0] a, input [31:0] d);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        do @(negedge aclk); while (!(awready && wready));
        @(posedge aclk);
        awvalid <= 1'b0;
        wvalid <= 1'b0;
        do @(negedge aclk); while (!bvalid);
        r = bresp;
        @(posedge aclk);
    endtask
    task rd(input [7:0] a);
        araddr <= a;
        arvalid <= 1'b1;
        do @(negedge aclk); while (!arready);
        @(posedge aclk);
        arvalid <= 1'b0;
        do @(negedge aclk); while (!rvalid);
        v = rdata;
        r = rresp;
        @(posedge aclk);
    endtask
    task fill(input [2:0] op, input [31:0] a, input [3:0] e, input [3:0] b, input c);
        em <= e;
        bm <= b;
        chk <= c;
        wr(8'h04, a);
        wr(8'h0c, {29'h0, op});
        do rd(8'h18); while (v[1:0] !== 2'b00);
    endtask
    task ld(input [31:0] a, input [63:0] x);
        wr(8'h04, a);
        wr(8'h0c, 32'h3);
        rd(8'h20);
        check("load_lo", v, x[31:0]);
        rd(8'h24);
        check("load_hi", v, x[63:32]);
    endtask
    task line4(input [31:0] a);
        for (k = 0; k < 4; k = k + 1)
            ld({a[31:5], k[1:0], 3'h0}, i_resp_agent_model.elem(a, k[1:0]));
    endtask
    task pulses;
        check("restarts", n_rs, e_rs);
        check("bus_errs", n_be, e_be);
        check("cache_err", n_ce, e_ce);
    endtask
    task final_report;
        $display("checks %0d errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // Watchdog far past the sequence's length
    initial begin
        repeat (40000) @(posedge aclk);
        n_errors = n_errors + 1;
        final_report;
    end
    ////////////////////////////////////////
    // Main sequence
    initial begin
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd(8'h1c);
        check("fault_rst", v, 32'h0);
        rd(8'h40);
        check("unmapped", {v, 30'h0, r}, {32'h0, 32'h2});
        wr(8'h40, 32'h1);
        check("unmap_wr", r, 2'h2);
        // Arrays start unknown: clear them with faults off
        wr(8'h00, 32'h1);
        wr(8'h08, 32'h0);
        for (w = 0; w < 2; w = w + 1) for (s = 0; s < 4; s = s + 1) begin
            wr(8'h04, w * 32'h2000 + s * 32'h20);
            wr(8'h0c, 32'h1);
            for (k = 0; k < 4; k = k + 1) begin
                wr(8'h04, w * 32'h2000 + s * 32'h20 + k * 8);
                wr(8'h0c, 32'h2);
            end
        end
        wr(8'h00, 32'h0);
        wr(8'h10, 32'h1234_5678);
        wr(8'h14, 32'h9abc_def0);
        wr(8'h04, 32'h0000_2048);
        wr(8'h0c, 32'h2);
        ld(32'h0000_0048, 64'h0);
        ld(32'h0000_2048, 64'h9abc_def0_1234_5678);
        fill(3'h4, 32'h0000_2050, 4'h0, 4'h0, 1'b0);
        e_rs = e_rs + 1;
        line4(32'h0000_2050);
        slow <= 1'b1;
        fill(3'h4, 32'h0000_2050, 4'ha, 4'h4, 1'b0);
        slow <= 1'b0;
        e_rs = e_rs + 1;
        pulses;
        e_ce = e_ce + 1;
        ld(32'h0000_2040, i_resp_agent_model.elem(32'h2050, 2'h0));
        rd(8'h1c);
        check("fault_dat", v, 32'h0200_0000);
        wr(8'h1c, 32'h0200_0000);
        fill(3'h4, 32'h0000_0060, 4'h0, 4'hf, 1'b1);
        fill(3'h5, 32'h0000_2060, 4'h0, 4'he, 1'b0);
        e_rs = e_rs + 2;
        line4(32'h0000_0060);
        line4(32'h0000_2060);
        pulses;
        fill(3'h4, 32'h0000_0020, 4'h1, 4'h0, 1'b0);
        e_be = e_be + 1;
        rd(8'h18);
        check("stat_bus", v[2], 1'b1);
        fill(3'h4, 32'h0000_0040, 4'h0, 4'h2, 1'b0);
        e_rs = e_rs + 1;
        wr(8'h00, 32'h1);
        ld(32'h0000_0048, i_resp_agent_model.elem(32'h40, 2'h1));
        pulses;
        wr(8'h00, 32'h0);
        fill(3'h4, 32'h0000_0000, 4'h0, 4'h1, 1'b0);
        e_ce = e_ce + 1;
        check("cache_err", n_ce, e_ce);
        rd(8'h1c);
        check("fault_bus", v, 32'h0400_0000);
        final_report;
    end
endmodule // read_response_integrity_bench
`default_nettype wire
